// ---- hw/tcm_pkg.sv ----
package tcm_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int PRE_W = 15;
  // Register byte offsets
  localparam logic [7:0] OFF_CLK_EN = 8'h00;
  localparam logic [7:0] OFF_PRESCALE = 8'h04;
  localparam logic [7:0] OFF_MODE_HI = 8'h08;
  localparam logic [7:0] OFF_MODE_LO = 8'h0C;
  localparam logic [7:0] OFF_PERIOD = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  localparam logic [7:0] OFF_CAPTURE = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  // Field positions
  localparam int GATE_BIT = 0;
  localparam int PRS_A_LSB = 0;
  localparam int PRS_B_LSB = 4;
  localparam int OPCLK_BIT = 7;
  localparam int CCLK_BIT = 4;
  localparam int TRIG_LSB = 0;
  localparam int MODE_LSB = 0;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int ST_EVENT = 0;
  localparam int ST_CAPT = 1;
  // Trigger source codes
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_EDGE = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_MASTER = 3'h4;
  // Mode codes (upper three bits, or all four)
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [3:0] MODE_EVENT = 4'h6;
  localparam logic [2:0] MODE_ONECOUNT = 3'h4;
  localparam logic [3:0] MODE_CAP_ONE = 4'hC;
  // Reset value and AXI response codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_ARMED = 3'b010,
    CH_RUN = 3'b100
  } tcm_ch_t;

  typedef struct packed {
    tcm_ch_t st;
    logic [PRE_W-1:0] pre;
    logic [2:0] pin_s;
    logic [7:0] clk_en;
    logic [7:0] prs;
    logic [7:0] mode_h;
    logic [7:0] mode_l;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] capt;
    logic tout;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcm_state_t;
endpackage

// ---- hw/tcm_timer.sv ----
`timescale 1ns/1ns
// What this block does
// RL1 - Unit clock gate bit 0 stops the whole unit when clear, runs when set. A software stop still sends the channel to idle while gated.
// RL2 - Operation clock A is system clock divided by two to the prescaler field.
// RL3 - Mode high bit 7 picks operation clock A (0) or B (1).
// RL4 - Mode high bit 4 picks operation clock (0) or input pin edges (1).
// RL5 - Trigger 000 software only, 001 pin edge, 010 both pin edges.
// RL6 - Trigger 100 uses master channel interrupt as start; other codes prohibited.
// RL7 - Mode 000x is interval timer, counting down.
// RL8 - Mode 010x is capture mode, counting up between input pulses.
// RL9 - Mode 0110 is event counter, counting down on external events.
// RL10 - Mode 100x is one-count mode, counting down after each trigger.
// RL11 - Mode 1100 is capture and one-count, counting up over input width.
// RL12 - Interval or capture: lowest mode bit raises interrupt and toggles output at start.
// RL13 - Interval period equals period register plus one count clock periods.
// RL14 - Interval timer reloads from period register and interrupts on expiry.
module tcm_timer
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel pins and events
  input wire logic channel_input_pin,
  input wire logic master_irq,
  output logic timer_out,
  output logic irq
);

  tcm_state_t q, d;

  function automatic logic pow2_tick(input logic [PRE_W-1:0] c,
                                     input logic [3:0] n);
    logic [PRE_W-1:0] m;
    // Tick when the low n bits of the free counter are all ones
    m = PRE_W'((32'd1 << n) - 32'd1);
    return (c & m) == m;
  endfunction

  logic unit_en, tick_a, tick_b, op_tick, count_tick;
  logic pin_rise, pin_fall, trig, start_sw, stop_sw, ev, cap_ev;
  logic is_int, is_cap, is_evt, is_one, is_capone, md0;
  logic [2:0] sts;
  logic wr_do;

  always_comb begin
    d = q;
    ev = 1'b0;
    cap_ev = 1'b0;
    start_sw = 1'b0;
    stop_sw = 1'b0;
    unit_en = q.clk_en[GATE_BIT];
    d.pin_s = {q.pin_s[1:0], channel_input_pin};
    pin_rise = q.pin_s[1] && !q.pin_s[2];
    pin_fall = !q.pin_s[1] && q.pin_s[2];
    // Prescaler only runs while the unit is supplied
    if (unit_en) d.pre = q.pre + 1'b1; // see RL1
    tick_a = unit_en && pow2_tick(q.pre, q.prs[PRS_A_LSB +: 4]); // see RL2
    tick_b = unit_en && pow2_tick(q.pre, q.prs[PRS_B_LSB +: 4]);
    op_tick = q.mode_h[OPCLK_BIT] ? tick_b : tick_a; // see RL3
    count_tick = q.mode_h[CCLK_BIT] ? (unit_en && pin_rise) : op_tick; // see RL4
    sts = q.mode_h[TRIG_LSB +: 3];
    unique case (sts)
      TRIG_EDGE: trig = pin_rise; // see RL5
      TRIG_BOTH: trig = pin_rise || pin_fall; // see RL5
      TRIG_MASTER: trig = master_irq; // see RL6
      default: trig = 1'b0;
    endcase
    trig = trig && unit_en;
    md0 = q.mode_l[MODE_LSB];
    is_int = q.mode_l[MODE_LSB+1 +: 3] == MODE_INTERVAL;
    is_cap = q.mode_l[MODE_LSB+1 +: 3] == MODE_CAPTURE;
    is_evt = q.mode_l[MODE_LSB +: 4] == MODE_EVENT;
    is_one = q.mode_l[MODE_LSB+1 +: 3] == MODE_ONECOUNT;
    is_capone = q.mode_l[MODE_LSB +: 4] == MODE_CAP_ONE;
    // AXI write: address and data in either order
    if (q.awready && s_axi_awvalid) begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    wr_do = q.aw_have && q.w_have && !q.bvalid;
    if (wr_do) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (q.awaddr)
        OFF_CLK_EN: if (q.wstrb[0]) d.clk_en = q.wdata[7:0];
        OFF_PRESCALE: if (q.wstrb[0]) d.prs = q.wdata[7:0];
        OFF_MODE_HI: if (q.wstrb[0]) d.mode_h = q.wdata[7:0];
        OFF_MODE_LO: if (q.wstrb[0]) d.mode_l = q.wdata[7:0];
        OFF_PERIOD: begin
          if (q.wstrb[0]) d.period[7:0] = q.wdata[7:0];
          if (q.wstrb[1]) d.period[15:8] = q.wdata[15:8];
        end
        OFF_CTRL: begin
          start_sw = q.wstrb[0] && q.wdata[CTRL_START];
          stop_sw = q.wstrb[0] && q.wdata[CTRL_STOP];
        end
        OFF_COUNT, OFF_CAPTURE: ;
        OFF_IRQ_STAT: if (q.wstrb[0]) d.stat = q.stat & ~q.wdata[1:0];
        OFF_IRQ_MASK: if (q.wstrb[0]) d.mask = q.wdata[1:0];
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    // Channel engine; a gated unit freezes in place except for a software stop to idle
    if (unit_en) begin // see RL1
      unique case (q.st)
        CH_IDLE: begin
          if (start_sw) begin
            if (is_int || is_evt) begin // see RL7 RL9
              d.cnt = q.period;
              d.st = CH_RUN;
            end else if (is_cap) begin // see RL8
              d.cnt = '0;
              d.st = CH_RUN;
            end else if (is_one || is_capone) begin // see RL10 RL11
              d.st = CH_ARMED;
            end
            // Start-time interrupt only where the mode allows it
            if ((is_int || is_cap) && md0) begin // see RL12
              ev = 1'b1;
              d.tout = !q.tout;
            end
          end
        end
        CH_ARMED: begin
          if (trig) begin
            d.cnt = is_one ? q.period : '0; // see RL10 RL11
            d.st = CH_RUN;
          end
        end
        CH_RUN: begin
          if (is_int || is_evt) begin
            if (count_tick) begin
              // Zero is a counted state, so period is N+1 ticks
              if (q.cnt == '0) begin // see RL13
                d.cnt = q.period; // see RL14
                ev = 1'b1; // see RL14
                d.tout = !q.tout;
              end else begin
                d.cnt = q.cnt - 1'b1; // see RL7 RL9
              end
            end
          end else if (is_cap) begin
            if (trig) begin
              d.capt = q.cnt;
              d.cnt = '0;
              ev = 1'b1;
              cap_ev = 1'b1;
            end else if (count_tick) begin
              d.cnt = q.cnt + 1'b1; // see RL8
            end
          end else if (is_one) begin
            if (trig && md0) begin // see RL10
              d.cnt = q.period;
              ev = 1'b1;
            end else if (count_tick) begin
              if (q.cnt == '0) begin
                ev = 1'b1;
                d.tout = !q.tout;
                d.st = CH_ARMED;
              end else begin
                d.cnt = q.cnt - 1'b1; // see RL10
              end
            end
          end else if (is_capone) begin
            // Width ends on the falling edge of the input
            if (pin_fall) begin
              d.capt = q.cnt;
              ev = 1'b1;
              cap_ev = 1'b1;
              d.st = CH_ARMED;
            end else if (count_tick) begin
              d.cnt = q.cnt + 1'b1; // see RL11
            end
          end else begin
            // Prohibited mode written while running: park
            d.st = CH_IDLE;
          end
        end
        default: d.st = CH_IDLE;
      endcase
    end
    if (stop_sw) d.st = CH_IDLE;
    // Hardware set wins over a same-cycle clear
    if (ev) d.stat[ST_EVENT] = 1'b1;
    if (cap_ev) d.stat[ST_CAPT] = 1'b1;
    d.irq = |(d.stat & d.mask);
    // AXI read
    if (q.arready && s_axi_arvalid) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      unique case (s_axi_araddr)
        OFF_CLK_EN: d.rdata[7:0] = q.clk_en;
        OFF_PRESCALE: d.rdata[7:0] = q.prs;
        OFF_MODE_HI: d.rdata[7:0] = q.mode_h;
        OFF_MODE_LO: d.rdata[7:0] = q.mode_l;
        OFF_PERIOD: d.rdata[CNT_W-1:0] = q.period;
        OFF_CTRL: d.rdata[2:0] = q.st;
        OFF_COUNT: d.rdata[CNT_W-1:0] = q.cnt;
        OFF_CAPTURE: d.rdata[CNT_W-1:0] = q.capt;
        OFF_IRQ_STAT: d.rdata[1:0] = q.stat;
        OFF_IRQ_MASK: d.rdata[1:0] = q.mask;
        default: d.rresp = RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= CH_IDLE;
      q.clk_en <= RST_BYTE;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign timer_out = q.tout;
  assign irq = q.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_gate_freeze;
    !q.clk_en[GATE_BIT] |=> (q.cnt == $past(q.cnt)) && (q.pre == $past(q.pre));
  endproperty
  a_gate_freeze: assert property (p_gate_freeze) // see RL1
    else $error("gated unit changed counter state");
  property p_prescale_div1;
    (unit_en && q.prs[PRS_A_LSB +: 4] == 4'h0) |-> tick_a;
  endproperty
  a_prescale_div1: assert property (p_prescale_div1) // see RL2
    else $error("prescaler zero did not tick every cycle");
  property p_prescale_div2;
    (unit_en && q.prs[PRS_A_LSB +: 4] == 4'h1) |-> tick_a == q.pre[0];
  endproperty
  a_prescale_div2: assert property (p_prescale_div2) // see RL2
    else $error("divide by two out of step with the free counter");
  property p_opclk_sel;
    (unit_en && !q.pre[0] && q.prs[PRS_A_LSB +: 4] == 4'h0
     && q.prs[PRS_B_LSB +: 4] != 4'h0) |-> op_tick == !q.mode_h[OPCLK_BIT];
  endproperty
  a_opclk_sel: assert property (p_opclk_sel) // see RL3
    else $error("wrong operation clock selected");
  property p_pin_count;
    (q.mode_h[CCLK_BIT] && count_tick) |-> pin_rise;
  endproperty
  a_pin_count: assert property (p_pin_count) // see RL4
    else $error("pin count clock ticked without an edge");
  property p_sw_only;
    (sts == TRIG_SW) |-> !trig;
  endproperty
  a_sw_only: assert property (p_sw_only) // see RL5
    else $error("hardware trigger with software-only source");
  property p_master_trig;
    (sts == TRIG_MASTER && master_irq && unit_en) |-> trig;
  endproperty
  a_master_trig: assert property (p_master_trig) // see RL6
    else $error("master interrupt not used as trigger");
  property p_down_count;
    (q.st == CH_RUN && (is_int || is_evt) && count_tick && unit_en
     && q.cnt != '0) |=> q.cnt == $past(q.cnt) - 1'b1;
  endproperty
  a_down_count: assert property (p_down_count) // see RL7
    else $error("interval or event counter did not count down");
  property p_up_count;
    (q.st == CH_RUN && (is_cap || is_capone) && count_tick && !trig
     && !pin_fall) |=> q.cnt == $past(q.cnt) + 1'b1;
  endproperty
  a_up_count: assert property (p_up_count) // see RL8
    else $error("capture counter did not count up");
  property p_one_end;
    (q.st == CH_RUN && is_one && count_tick && q.cnt == '0 && !trig
     && !stop_sw) |=> q.st == CH_ARMED && q.stat[ST_EVENT];
  endproperty
  a_one_end: assert property (p_one_end) // see RL10
    else $error("one-count did not stop with interrupt");
  property p_start_irq;
    (q.st == CH_IDLE && start_sw && unit_en && (is_int || is_cap))
    |=> q.stat[ST_EVENT] == $past(md0) || $past(q.stat[ST_EVENT]);
  endproperty
  a_start_irq: assert property (p_start_irq) // see RL12
    else $error("start interrupt does not follow lowest mode bit");
  property p_reload;
    (q.st == CH_RUN && is_int && count_tick && q.cnt == '0)
    |=> q.cnt == $past(q.period) && q.stat[ST_EVENT] && irq == |(q.stat & q.mask);
  endproperty
  a_reload: assert property (p_reload) // see RL14
    else $error("interval expiry did not reload and interrupt");
  c_interval_wrap: cover property (q.st == CH_RUN && is_int && count_tick
    && q.cnt == '0);
  c_capture: cover property (q.st == CH_RUN && is_cap && trig);
  c_one_count: cover property (q.st == CH_ARMED && is_one && trig);
  c_irq: cover property (irq);
endmodule

// ---- tb/tcm_tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
  import tcm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic channel_input_pin = 1'b0;
  logic master_irq = 1'b0;
  logic timer_out;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 37;
  logic [31:0] rv, c1, c2, p, v, n;
  logic [1:0] rr;
  logic [7:0] prs_t [4] = '{8'h00, 8'h03, 8'h20, 8'h05};
  logic [7:0] mh_t [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
  int sh_t [4] = '{0, 3, 2, 0};
  logic [2:0] tc_t [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  logic [31:0] te_t [4] = '{32'h4, 32'h4, 32'h4, 32'h2};

  tcm_timer DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .channel_input_pin(channel_input_pin),
    .master_irq(master_irq), .timer_out(timer_out), .irq(irq)
  );

  always #5 aclk = ~aclk;

  // Whole run needs under two thousand cycles; this only cuts a hang
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Extra edge at the end keeps back-to-back calls off one time step
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    rd(a, rv, rr);
    `CHK(nm, ex, rv)
    `CHK("rresp", RESP_OKAY, rr)
  endtask

  task setup(input logic [7:0] prs, mh, ml, input logic [31:0] per);
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    wr(OFF_PRESCALE, {24'h0, prs}, RESP_OKAY);
    wr(OFF_MODE_HI, {24'h0, mh}, RESP_OKAY);
    wr(OFF_MODE_LO, {24'h0, ml}, RESP_OKAY);
    wr(OFF_PERIOD, per, RESP_OKAY);
    wr(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
  endtask

  // Pin held long enough to pass the two-stage synchroniser
  task pin_pulse();
    channel_input_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    channel_input_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task meas(output logic [31:0] cnt);
    logic t0;
    t0 = timer_out;
    while (timer_out === t0) @(posedge aclk);
    t0 = timer_out;
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while (timer_out === t0);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int a = 0; a <= 36; a += 4)
      rchk(a[7:0], (a == 20) ? 32'h1 : 32'h0, "reset value");
    rd(8'h40, rv, rr);
    `CHK("unmapped rresp", RESP_SLVERR, rr)
    wr(8'h40, 32'h1, RESP_SLVERR);
    v = $random(seed);
    wr(OFF_PRESCALE, v, RESP_OKAY);
    rchk(OFF_PRESCALE, v & 32'hFF, "prescaler");
    wr(OFF_PERIOD, v, RESP_OKAY);
    rchk(OFF_PERIOD, v & 32'hFFFF, "period");
    wr(OFF_COUNT, v, RESP_OKAY);
    rchk(OFF_COUNT, 32'h0, "count read only");
    $display("test registers done");

    wr(OFF_CLK_EN, 32'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      p = 2 + ({$random(seed)} % 8);
      setup(prs_t[i], mh_t[i], 8'h01, p);
      meas(n);
      meas(n);
      `CHK("interval", (p + 1) << sh_t[i], n)
    end
    $display("test interval done");

    p = 10 + ({$random(seed)} % 16);
    setup(8'h00, 8'h10, 8'h00, p);
    repeat (20) @(posedge aclk);
    rchk(OFF_COUNT, p, "no pin edge");
    setup(8'h00, 8'h10, 8'h06, p);
    repeat (3) pin_pulse();
    rchk(OFF_COUNT, p - 3, "event count");
    $display("test count clock done");

    setup(8'h00, 8'h00, 8'h04, 32'hFFFF);
    rd(OFF_COUNT, c1, rr);
    rd(OFF_COUNT, c2, rr);
    `CHK("count up", 1'b1, c2 > c1)
    wr(OFF_CLK_EN, 32'h0, RESP_OKAY);
    rd(OFF_COUNT, c1, rr);
    repeat (10) @(posedge aclk);
    rd(OFF_COUNT, c2, rr);
    `CHK("gated count", c1, c2)
    wr(OFF_CLK_EN, 32'h1, RESP_OKAY);
    $display("test capture and gate done");

    setup(8'h00, 8'h00, 8'h00, 32'h0FFF);
    rchk(OFF_IRQ_STAT, 32'h0, "quiet start");
    setup(8'h00, 8'h00, 8'h01, 32'h0FFF);
    rchk(OFF_IRQ_STAT, 32'h1, "start event");
    wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    `CHK("irq unmasked", 1'b1, irq)
    wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    rchk(OFF_IRQ_STAT, 32'h0, "status cleared");
    $display("test interrupt done");

    for (int i = 0; i < 4; i++) begin
      setup(8'h00, {5'h0, tc_t[i]}, 8'h08, 32'hFFFF);
      rchk(OFF_CTRL, 32'h2, "armed");
      if (tc_t[i] == TRIG_MASTER) begin
        master_irq <= 1'b1;
        @(posedge aclk);
        master_irq <= 1'b0;
        repeat (2) @(posedge aclk);
      end else begin
        pin_pulse();
      end
      rchk(OFF_CTRL, te_t[i], "triggered");
    end
    // Short one-count run must end armed with its event
    setup(8'h00, {5'h0, TRIG_MASTER}, 8'h08, 32'h3);
    master_irq <= 1'b1;
    @(posedge aclk);
    master_irq <= 1'b0;
    repeat (12) @(posedge aclk);
    rchk(OFF_CTRL, 32'h2, "one-count end");
    rchk(OFF_IRQ_STAT, 32'h1, "one-count event");
    setup(8'h00, {5'h0, TRIG_EDGE}, 8'h04, 32'h0);
    pin_pulse();
    rchk(OFF_IRQ_STAT, 32'h3, "capture events");
    setup(8'h00, {5'h0, TRIG_EDGE}, 8'h0C, 32'h0);
    pin_pulse();
    rchk(OFF_CTRL, 32'h2, "width done");
    rchk(OFF_IRQ_STAT, 32'h3, "width events");
    rd(OFF_CAPTURE, c1, rr);
    `CHK("width counted", 1'b1, c1 > 0)
    setup(8'h00, 8'h00, 8'h0F, 32'h10);
    rchk(OFF_CTRL, 32'h1, "prohibited mode");
    $display("test triggers done");
    give_verdict();
  end
endmodule
